// ==== design/itc_defines.vh ====
// Constants for the input terminal conditioning block
`ifndef ITC_DEFINES_VH
`define ITC_DEFINES_VH
// ==========================================================
// Clock and timing
`define ITC_CLK_MHZ 100
`define ITC_BASE_TICK_US 1000
`define ITC_MS_CYCLES (`ITC_BASE_TICK_US * `ITC_CLK_MHZ)
`define ITC_TICKS_PER_STEP 10
`define ITC_PULSE_MAX_CKHZ 16'd10000
`define ITC_PULSE_SCALE 16'd10
`define ITC_UPDOWN_DP1_SCALE 20'd10
// ==========================================================
// Register indices (byte address is four times the index)
`define ITC_R_POL_A 0
`define ITC_R_POL_P 1
`define ITC_R_DFILT 2
`define ITC_R_CLOSE1 3
`define ITC_R_OPEN1 6
`define ITC_R_RAMP 9
`define ITC_R_CURVE 10
`define ITC_R_BELOW 11
`define ITC_R_C1_BASE 6'd12
`define ITC_R_AI1_FILT 16
`define ITC_R_C2_BASE 6'd17
`define ITC_R_AI2_FILT 21
`define ITC_R_C3_BASE 6'd22
`define ITC_R_P_BASE 6'd26
`define ITC_R_P_FILT 30
`define ITC_R_LOCK 31
`define ITC_R_CTRL 32
`define ITC_NCFG 33
`define ITC_R_STATUS 33
`define ITC_R_AI1_SET 34
`define ITC_R_AI2_SET 35
`define ITC_R_P_SET 36
`define ITC_R_P_FREQ 37
// Offsets inside one two-point curve group
`define ITC_C_MIN_IN 0
`define ITC_C_MIN_SET 1
`define ITC_C_MAX_IN 2
`define ITC_C_MAX_SET 3
// ==========================================================
// Control register fields
`define ITC_CTRL_DP_LSB 0
`define ITC_CTRL_MODE_LSB 4
`define ITC_CTRL_AI1_CUR 8
`define ITC_CTRL_AI2_CUR 9
`define ITC_MODE_SHUTTLE 3'd5
// ==========================================================
// Reset values
`define ITC_RST_DFILT 20'd10
`define ITC_RST_RAMP 20'd1000
`define ITC_RST_CURVE 20'h00321
`define ITC_RST_MAX_IN 20'd1000
`define ITC_RST_MAX_SET 20'd1000
`define ITC_RST_AFILT 20'd10
`define ITC_RST_P_MAX_IN 20'd5000
`define ITC_RST_LOCK 20'd100
`define ITC_RST_CTRL 20'h00002
`endif

// ==== design/itc_top.v ====
// Input terminal conditioning: digital filters, delays, analog and pulse curves
// Operation
// R1: Polarity bit per input: 0 high, 1 low
// R2: High polarity: closed to return is active
// R3: Low polarity: closed to return is inactive
// R4: Noise filter time, 0 to 1 s
// R5: Close delay on inputs 1 to 3
// R6: Open delay on inputs 1 to 3
// R7: Up/down ramps frequency at set rate
// R8: Decimal point 1 scales ramp rate by ten
// R9: Each analog input selects one of five curves
// R10: Curves 1-3 two-point here; 4-5 elsewhere
// R11: Below min, digit 0: minimum setting
// R12: Below min, digit 1: exactly zero
// R13: Above maximum input treated as maximum
// R14: Endpoint settings span -100.0 to +100.0 percent
// R15: Curve 1 volts range and defaults
// R16: Current mode: 0.5 V per mA
// R17: Smoothing filter on analog and pulse inputs
// R18: Curves 2 and 3 behave like curve 1
// R19: Pulse rate mapped by two-point curve
// R20: Pulse rate only from pulse-capable input
// R21: Shuttle mode applies travel switch lock time
// R22: Accept state only after stable filter time
// R23: Linear interpolation, 0.1 percent resolution
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "itc_defines.vh"

module itc_top #(
  parameter [31:0] MS_CYCLES = `ITC_MS_CYCLES
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  // Field terminals, high when closed
  input wire digital_input_1,
  input wire digital_input_2,
  input wire digital_input_3,
  input wire digital_input_4,
  input wire digital_input_5,
  input wire pulse_capable_input,
  // Converter samples, 0.01 V or 0.01 mA units
  input wire [15:0] analog_input_1,
  input wire [15:0] analog_input_2,
  // Conditioned results
  output reg [5:0] input_active_q,
  output reg [15:0] ai1_setting_q,
  output reg [15:0] ai2_setting_q,
  output reg [15:0] pulse_setting_q,
  output reg [39:0] updown_freq_q,
  output reg travel_lock_q
);

  // ==========================================================
  // Functions
  // Reset value of a configuration word
  function [19:0] rst_val;
    input integer i;
    begin
      case (i)
        `ITC_R_DFILT: rst_val = `ITC_RST_DFILT;
        `ITC_R_RAMP: rst_val = `ITC_RST_RAMP;
        `ITC_R_CURVE: rst_val = `ITC_RST_CURVE;
        `ITC_R_AI1_FILT, `ITC_R_AI2_FILT, `ITC_R_P_FILT: rst_val = `ITC_RST_AFILT;
        `ITC_R_C1_BASE + `ITC_C_MAX_IN, `ITC_R_C2_BASE + `ITC_C_MAX_IN,
        `ITC_R_C3_BASE + `ITC_C_MAX_IN: rst_val = `ITC_RST_MAX_IN;
        `ITC_R_C1_BASE + `ITC_C_MAX_SET, `ITC_R_C2_BASE + `ITC_C_MAX_SET,
        `ITC_R_C3_BASE + `ITC_C_MAX_SET,
        `ITC_R_P_BASE + `ITC_C_MAX_SET: rst_val = `ITC_RST_MAX_SET;
        `ITC_R_P_BASE + `ITC_C_MAX_IN: rst_val = `ITC_RST_P_MAX_IN;
        `ITC_R_LOCK: rst_val = `ITC_RST_LOCK;
        `ITC_R_CTRL: rst_val = `ITC_RST_CTRL;
        default: rst_val = 20'h00000;
      endcase
    end
  endfunction

  // First word of a two-point curve group, curve 1..3
  function [5:0] curve_base;
    input [3:0] sel;
    begin
      case (sel)
        4'h1: curve_base = `ITC_R_C1_BASE;
        4'h2: curve_base = `ITC_R_C2_BASE;
        4'h3: curve_base = `ITC_R_C3_BASE;
        default: curve_base = `ITC_R_C1_BASE;
      endcase
    end
  endfunction

  // Two-point curve with clamping, signed 0.1 percent result
  function [15:0] crv_map;
    input integer v, vmin, vmax, smin, smax;
    input blo_zero;
    integer r;
    begin
      if (v < vmin) begin
        r = blo_zero ? 0 : smin; // R11 R12
      end else if (v >= vmax) begin
        r = smax; // R13
      end else begin
        r = smin + ((v - vmin) * (smax - smin)) / (vmax - vmin); // R23 R14
      end
      crv_map = r[15:0];
    end
  endfunction

  // Smoothing shift from a filter time in 10 ms units
  function [3:0] filt_shift;
    input [15:0] t;
    integer k;
    begin
      filt_shift = 4'd0;
      for (k = 0; k < 11; k = k + 1) begin
        if ((16'd1 << k) <= t) begin
          filt_shift = k[3:0] + 4'd1;
        end
      end
    end
  endfunction

  // ==========================================================
  // Register file and AHB-Lite slave
  reg [19:0] cfg_q [0:`ITC_NCFG-1]; // Software settings
  reg wr_pend_q; // Write data phase pending
  reg [5:0] wr_idx_q; // Word index of pending write
  reg [1:0] curve_bad_q; // Curve 4 or 5 or invalid picked
  reg [15:0] pfreq_q; // Measured pulse rate, 0.01 kHz
  wire acc_ok = hsel & htrans[1] & hready; // Valid address phase
  wire [5:0] acc_idx = haddr[7:2]; // Word index
  wire map_ok = (haddr[31:8] == 24'h000000); // Only the low window decodes
  integer i;

  // Read mux for one word
  function [31:0] rd_word;
    input [5:0] idx;
    begin
      rd_word = 32'h00000000;
      if (idx < `ITC_NCFG) begin
        rd_word = {12'h000, cfg_q[idx]};
      end else begin
        case (idx)
          `ITC_R_STATUS: rd_word = {22'h000000, curve_bad_q, 2'b00, input_active_q};
          `ITC_R_AI1_SET: rd_word = {16'h0000, ai1_setting_q};
          `ITC_R_AI2_SET: rd_word = {16'h0000, ai2_setting_q};
          `ITC_R_P_SET: rd_word = {16'h0000, pulse_setting_q};
          `ITC_R_P_FREQ: rd_word = {16'h0000, pfreq_q};
          default: rd_word = 32'h00000000;
        endcase
      end
    end
  endfunction

  // Bus phases: read data captured at the address edge, write at data edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_idx_q <= 6'h00;
      for (i = 0; i < `ITC_NCFG; i = i + 1) begin
        cfg_q[i] <= rst_val(i);
      end
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= acc_ok & hwrite & map_ok;
      wr_idx_q <= acc_idx;
      if (acc_ok & ~hwrite) begin
        hrdata <= map_ok ? rd_word(acc_idx) : 32'h00000000;
      end
      // Polarity word holds five digits, others sixteen bits
      if (wr_pend_q && (wr_idx_q < `ITC_NCFG)) begin
        cfg_q[wr_idx_q] <= (wr_idx_q == `ITC_R_POL_A) ? hwdata[19:0] : {4'h0, hwdata[15:0]};
      end
    end
  end

  // ==========================================================
  // Time base: 1 ms, 10 ms, 100 ms ticks
  reg [31:0] ms_cnt_q; // Cycle counter within a millisecond
  reg ms_tick_q; // One cycle per millisecond
  reg [3:0] cs_cnt_q; // Millisecond counter within 10 ms
  reg cs_tick_q; // One cycle per 10 ms
  reg [3:0] ds_cnt_q; // 10 ms counter within 100 ms
  reg ds_tick_q; // One cycle per 100 ms

  // Cascaded dividers keep each counter small
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_q <= 32'h00000000;
      ms_tick_q <= 1'b0;
      cs_cnt_q <= 4'h0;
      cs_tick_q <= 1'b0;
      ds_cnt_q <= 4'h0;
      ds_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= (ms_cnt_q == MS_CYCLES - 32'd1);
      ms_cnt_q <= (ms_cnt_q == MS_CYCLES - 32'd1) ? 32'h00000000 : ms_cnt_q + 32'd1;
      cs_tick_q <= 1'b0;
      ds_tick_q <= 1'b0;
      if (ms_tick_q) begin
        cs_tick_q <= (cs_cnt_q == `ITC_TICKS_PER_STEP - 1);
        cs_cnt_q <= (cs_cnt_q == `ITC_TICKS_PER_STEP - 1) ? 4'h0 : cs_cnt_q + 4'd1;
      end
      if (cs_tick_q) begin
        ds_tick_q <= (ds_cnt_q == `ITC_TICKS_PER_STEP - 1);
        ds_cnt_q <= (ds_cnt_q == `ITC_TICKS_PER_STEP - 1) ? 4'h0 : ds_cnt_q + 4'd1;
      end
    end
  end

  // ==========================================================
  // Pin synchronisers, taken when stages two and three agree
  wire [5:0] pins = {pulse_capable_input, digital_input_5, digital_input_4,
                     digital_input_3, digital_input_2, digital_input_1};
  reg [5:0] s1_q; // First stage, read only by second
  reg [5:0] s2_q; // Second stage
  reg [5:0] s3_q; // Third stage
  reg [5:0] stab_q; // Agreed pin level

  // Synchroniser chain with agreement hold
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      s3_q <= 6'h00;
      stab_q <= 6'h00;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stab_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & stab_q);
    end
  end

  // Polarity digits, one bit per terminal
  wire [5:0] pol = {cfg_q[`ITC_R_POL_P][0], cfg_q[`ITC_R_POL_A][16],
                    cfg_q[`ITC_R_POL_A][12], cfg_q[`ITC_R_POL_A][8],
                    cfg_q[`ITC_R_POL_A][4], cfg_q[`ITC_R_POL_A][0]}; // R1
  wire [5:0] act_raw = stab_q ^ pol; // R2 R3
  wire [5:0] deb; // Filtered state
  wire [2:0] dly; // Delayed state, inputs 1 to 3

  // ==========================================================
  // Noise filter per terminal
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_deb
      reg dq; // Accepted state
      reg [15:0] cnt_q; // Stable milliseconds so far
      // Restart on revert, accept after full time
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          dq <= 1'b0;
          cnt_q <= 16'h0000;
        end else if (act_raw[g] == dq) begin
          cnt_q <= 16'h0000; // R22
        end else if (cnt_q >= cfg_q[`ITC_R_DFILT][15:0]) begin
          dq <= act_raw[g]; // R4
          cnt_q <= 16'h0000;
        end else if (ms_tick_q) begin
          cnt_q <= cnt_q + 16'd1;
        end
      end
      assign deb[g] = dq;
    end

    // Close and open delays, 0.1 s units
    for (g = 0; g < 3; g = g + 1) begin : g_dly
      reg oq; // Delayed state
      reg [15:0] cnt_q; // Elapsed 100 ms steps
      wire [15:0] tgt = deb[g] ? cfg_q[`ITC_R_CLOSE1 + g][15:0]
                               : cfg_q[`ITC_R_OPEN1 + g][15:0];
      // Change passes once its own delay ran out
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          oq <= 1'b0;
          cnt_q <= 16'h0000;
        end else if (deb[g] == oq) begin
          cnt_q <= 16'h0000;
        end else if (cnt_q >= tgt) begin
          oq <= deb[g]; // R5 R6
          cnt_q <= 16'h0000;
        end else if (ds_tick_q) begin
          cnt_q <= cnt_q + 16'd1;
        end
      end
      assign dly[g] = oq;
    end
  endgenerate

  // ==========================================================
  // Pulse rate measurement on the pulse-capable pin alone
  reg p_prev_q; // Previous agreed level
  reg [15:0] pcnt_q; // Rising edges in the gate window
  wire p_rise = stab_q[5] & ~p_prev_q; // R20

  // 10 ms gate; count times ten gives 0.01 kHz units
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p_prev_q <= 1'b0;
      pcnt_q <= 16'h0000;
      pfreq_q <= 16'h0000;
    end else begin
      p_prev_q <= stab_q[5];
      if (cs_tick_q) begin
        pfreq_q <= (pcnt_q >= `ITC_PULSE_MAX_CKHZ / `ITC_PULSE_SCALE) ?
                   `ITC_PULSE_MAX_CKHZ : pcnt_q * `ITC_PULSE_SCALE;
        pcnt_q <= {15'h0000, p_rise};
      end else if (p_rise && (pcnt_q != 16'hffff)) begin
        pcnt_q <= pcnt_q + 16'd1;
      end
    end
  end

  // ==========================================================
  // Smoothing and curve mapping: channel 0, 1 analog, 2 pulse
  wire [15:0] ctrl = cfg_q[`ITC_R_CTRL][15:0];
  wire signed [17:0] a1x = {{2{analog_input_1[15]}}, analog_input_1};
  wire signed [17:0] a1v = ctrl[`ITC_CTRL_AI1_CUR] ? a1x >>> 1 : a1x; // R16
  wire signed [17:0] a2x = {{2{analog_input_2[15]}}, analog_input_2};
  wire signed [17:0] a2v = ctrl[`ITC_CTRL_AI2_CUR] ? a2x >>> 1 : a2x; // R16
  wire signed [17:0] ch_in [0:2];
  wire [15:0] ch_ft [0:2];
  wire [15:0] ch_set [0:2];
  wire [3:0] sel0 = cfg_q[`ITC_R_CURVE][3:0]; // R9
  wire [3:0] sel1 = cfg_q[`ITC_R_CURVE][7:4]; // R9
  wire [5:0] base [0:2];
  wire blo [0:2];
  assign ch_in[0] = a1v;
  assign ch_in[1] = a2v;
  assign ch_in[2] = {2'b00, pfreq_q};
  assign ch_ft[0] = cfg_q[`ITC_R_AI1_FILT][15:0];
  assign ch_ft[1] = cfg_q[`ITC_R_AI2_FILT][15:0];
  assign ch_ft[2] = cfg_q[`ITC_R_P_FILT][15:0];
  assign base[0] = curve_base(sel0); // R18
  assign base[1] = curve_base(sel1); // R18
  assign base[2] = `ITC_R_P_BASE; // R19
  assign blo[0] = cfg_q[`ITC_R_BELOW][0];
  assign blo[1] = cfg_q[`ITC_R_BELOW][4];
  assign blo[2] = 1'b0;

  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ch
      reg signed [17:0] y_q; // Smoothed value
      wire [3:0] k = filt_shift(ch_ft[g]);
      wire signed [17:0] diff = ch_in[g] - y_q;
      // Step toward the input each 10 ms, zero time follows at once
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          y_q <= 18'sh00000;
        end else if (k == 4'd0) begin
          y_q <= ch_in[g]; // R17
        end else if (cs_tick_q) begin
          y_q <= y_q + (diff >>> k); // R17
        end
      end
      assign ch_set[g] = crv_map(y_q,
        $signed(cfg_q[base[g] + `ITC_C_MIN_IN][15:0]),
        $signed(cfg_q[base[g] + `ITC_C_MAX_IN][15:0]),
        $signed(cfg_q[base[g] + `ITC_C_MIN_SET][15:0]),
        $signed(cfg_q[base[g] + `ITC_C_MAX_SET][15:0]), blo[g]); // R15 R19
    end
  endgenerate

  // Registered settings; curves 4 and 5 give zero here
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ai1_setting_q <= 16'h0000;
      ai2_setting_q <= 16'h0000;
      pulse_setting_q <= 16'h0000;
      curve_bad_q <= 2'b00;
    end else begin
      curve_bad_q <= {(sel1 < 4'h1) | (sel1 > 4'h3), (sel0 < 4'h1) | (sel0 > 4'h3)}; // R10
      ai1_setting_q <= curve_bad_q[0] ? 16'h0000 : ch_set[0];
      ai2_setting_q <= curve_bad_q[1] ? 16'h0000 : ch_set[1];
      pulse_setting_q <= ch_set[2];
    end
  end

  // ==========================================================
  // Conditioned terminals and up/down ramp (input 4 up, input 5 down)
  wire [19:0] rate = {4'h0, cfg_q[`ITC_R_RAMP][15:0]};
  wire [1:0] dp = ctrl[`ITC_CTRL_DP_LSB +: 2];
  wire [19:0] step = (dp == 2'd1) ? rate * `ITC_UPDOWN_DP1_SCALE : rate; // R8
  wire [39:0] step40 = {20'h00000, step};
  wire up_on = input_active_q[3] & ~input_active_q[4];
  wire dn_on = input_active_q[4] & ~input_active_q[3];

  // Micro-hertz accumulator, rate added each ms
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_active_q <= 6'h00;
      updown_freq_q <= 40'h0000000000;
    end else begin
      input_active_q <= {deb[5:3], dly};
      if (ms_tick_q && up_on) begin
        updown_freq_q <= (updown_freq_q > ~step40) ? {40{1'b1}} : updown_freq_q + step40; // R7
      end else if (ms_tick_q && dn_on) begin
        updown_freq_q <= (updown_freq_q < step40) ? 40'h0000000000 : updown_freq_q - step40; // R7
      end
    end
  end

  // ==========================================================
  // Travel switch lock in shuttle mode (switches on inputs 1 and 2)
  reg [1:0] sw_prev_q; // Previous switch states
  reg [15:0] lock_cnt_q; // Remaining lock, 10 ms units
  wire shuttle = (ctrl[`ITC_CTRL_MODE_LSB +: 3] == `ITC_MODE_SHUTTLE);
  wire sw_hit = |(input_active_q[1:0] & ~sw_prev_q);

  // Switch hit starts the lock; hits ignored while locked
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_prev_q <= 2'b00;
      lock_cnt_q <= 16'h0000;
      travel_lock_q <= 1'b0;
    end else begin
      sw_prev_q <= input_active_q[1:0];
      if (!shuttle) begin
        lock_cnt_q <= 16'h0000;
        travel_lock_q <= 1'b0;
      end else if (sw_hit && !travel_lock_q) begin
        lock_cnt_q <= cfg_q[`ITC_R_LOCK][15:0]; // R21
        travel_lock_q <= (cfg_q[`ITC_R_LOCK][15:0] != 16'h0000);
      end else if (cs_tick_q && (lock_cnt_q != 16'h0000)) begin
        lock_cnt_q <= lock_cnt_q - 16'd1;
        travel_lock_q <= (lock_cnt_q != 16'd1);
      end
    end
  end

endmodule // itc_top

// ==== test/itc_field.sv ====
// Field model: switches, sensors, pulse source
`timescale 1ns/1ps
module itc_field (
  // Clock
  input wire hclk,
  // Bench commands
  input wire [5:0] contact,
  input wire [7:0] half,
  input wire on_di5,
  input wire [15:0] a1_in,
  input wire [15:0] a2_in,
  // Terminal pins
  output wire [4:0] di,
  output wire hdi,
  output wire [15:0] ai1,
  output wire [15:0] ai2
);
  // ====================
  // Square wave source
  reg [7:0] cnt_q;
  reg sq_q;
  // Toggle every half period; still when off
  always @(posedge hclk) begin
    if (half == 8'h0) begin
      cnt_q <= 8'h0;
      sq_q <= 1'b0;
    end else if (cnt_q == half - 8'h1) begin
      cnt_q <= 8'h0;
      sq_q <= ~sq_q;
    end else begin
      cnt_q <= cnt_q + 8'h1;
    end
  end
  // ====================
  // Pins
  // Closed to common return reads high
  assign di = {(on_di5 && half != 8'h0) ? sq_q : contact[4], contact[3:0]};
  // Pulses on the pulse pin unless moved
  assign hdi = (half != 8'h0 && !on_di5) ? sq_q : contact[5];
  // Sensors follow their set values
  assign ai1 = a1_in;
  assign ai2 = a2_in;
endmodule // itc_field

// ==== test/itc_top_monitor.sv ====
// Port checks of the conditioning block
`timescale 1ns/1ps
module itc_top_monitor (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire hresp,
  // Results
  input wire [5:0] input_active_q,
  input wire [15:0] ai1_setting_q,
  input wire [15:0] ai2_setting_q,
  input wire [15:0] pulse_setting_q,
  input wire [39:0] updown_freq_q,
  input wire travel_lock_q
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ====================
  // Bus answers
  AST_READY: assert property (hreadyout) else $error("wait");
  AST_OKAY: assert property (!hresp) else $error("error resp");
  AST_UNMAPPED: assert property (
    hsel && htrans[1] && hready && !hwrite && haddr[31:8] != 0 |=> hrdata == 0)
    else $error("unmapped read");
  // ====================
  // Settings within span
  AST_AI1_SPAN: assert property (
    $signed(ai1_setting_q) >= -1000 && $signed(ai1_setting_q) <= 1000)
    else $error("ai1 span");
  AST_AI2_SPAN: assert property (
    $signed(ai2_setting_q) >= -1000 && $signed(ai2_setting_q) <= 1000)
    else $error("ai2 span");
  AST_P_SPAN: assert property (
    $signed(pulse_setting_q) >= -1000 && $signed(pulse_setting_q) <= 1000)
    else $error("pulse span");
  // ====================
  // Ramp follows up/down
  AST_UD_HOLD: assert property (
    (input_active_q[3] == input_active_q[4]) [*3] |-> $stable(updown_freq_q))
    else $error("ramp moved");
  AST_UD_UP: assert property (
    (input_active_q[4:3] == 2'b01) [*3] |-> updown_freq_q >= $past(updown_freq_q))
    else $error("ramp fell");
  AST_UD_DOWN: assert property (
    (input_active_q[4:3] == 2'b10) [*3] |-> updown_freq_q <= $past(updown_freq_q))
    else $error("ramp rose");
  // Lock needs a switch
  AST_LOCK_CAUSE: assert property (
    $rose(travel_lock_q) |-> (|input_active_q[1:0]) || (|$past(input_active_q[1:0])))
    else $error("lock no switch");
endmodule // itc_top_monitor

// ==== test/test_itc_top.sv ====
// Testbench of the input terminal conditioning block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
`define WT(c) begin n = 0; while (!(c)) begin @(negedge hclk); n++; \
  if (n > 5000) begin miscompares++; end_of_test; end end end
module test_itc_top;
  // ====================
  // Signals
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, on_di5 = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0] htrans = 0;
  logic [5:0] contact = 0;
  logic [7:0] half = 0;
  logic [15:0] a1 = 0, a2 = 0;
  wire hreadyout, hresp, hdi, lock;
  wire [31:0] hrdata;
  wire [4:0] di;
  wire [15:0] ai1, ai2, s1, s2, sp;
  wire [5:0] act;
  wire [39:0] frq;
  int miscompares = 0;
  int comparisons = 0;
  int n, i, k, v1, v2, e1, e2, rate;
  logic [31:0] r, w;
  logic [39:0] a;
  int ri[10] = '{0, 2, 9, 10, 14, 15, 16, 28, 31, 32};
  int rv[10] = '{0, 10, 1000, 'h321, 1000, 1000, 10, 5000, 100, 2};
  // ====================
  // Instances
  itc_top #(.MS_CYCLES(32'd10)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .digital_input_1(di[0]), .digital_input_2(di[1]), .digital_input_3(di[2]),
    .digital_input_4(di[3]), .digital_input_5(di[4]), .pulse_capable_input(hdi),
    .analog_input_1(ai1), .analog_input_2(ai2), .input_active_q(act),
    .ai1_setting_q(s1), .ai2_setting_q(s2), .pulse_setting_q(sp),
    .updown_freq_q(frq), .travel_lock_q(lock));
  itc_field FLD (.hclk(hclk), .contact(contact), .half(half), .on_di5(on_di5),
    .a1_in(a1), .a2_in(a2), .di(di), .hdi(hdi), .ai1(ai1), .ai2(ai2));
  // 100 MHz clock
  initial forever #5 hclk = ~hclk;
  // ====================
  // Tasks
  task end_of_test;
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Wait for hready
  task hs;
    int m;
    m = 0;
    do begin @(posedge hclk); m++; end while (hreadyout !== 1'b1 && m < 100);
    if (m >= 100) begin miscompares++; end_of_test; end
  endtask
  // One word transfer
  task xfer(input [31:0] ad, input wr, input [31:0] d, output [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= 2'h2;
    hwrite <= wr;
    hs;
    htrans <= 2'h0;
    hwdata <= d;
    hs;
    q = hrdata;
  endtask
  task wr(input [5:0] ix, input [31:0] d);
    xfer({24'h0, ix, 2'h0}, 1'b1, d, r);
  endtask
  task rd(input [5:0] ix);
    xfer({24'h0, ix, 2'h0}, 1'b0, 32'h0, r);
  endtask
  // Ramp change over 5 ms
  task meas;
    @(negedge hclk) a = frq;
    repeat (50) @(negedge hclk);
    a = frq - a;
  endtask
  // Curve from 2 V/-50 % to 8 V/+70 %
  function automatic int crv(int v, bit z);
    if (v < 200) return z ? 0 : -500;
    if (v > 800) v = 800;
    return -500 + 2 * (v - 200);
  endfunction
  // ====================
  // Main sequence
  initial begin
    void'($urandom(32'h640bcc05));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values and unmapped place
    for (i = 0; i < 10; i++) begin
      rd(6'(ri[i]));
      `CHK(r, 32'(rv[i]))
    end
    xfer(32'h100, 1'b1, 32'h1234, r);
    xfer(32'h100, 1'b0, 32'h0, r);
    `CHK(r, 32'h0)
    // Delay words read back
    for (i = 3; i < 9; i++) begin
      w = $urandom;
      wr(6'(i), w);
      rd(6'(i));
      `CHK(r, {16'h0, w[15:0]})
      wr(6'(i), 32'h0);
    end
    // Polarity per terminal, unfiltered
    wr(2, 0);
    for (k = 0; k < 8; k++) begin
      w = $urandom;
      @(posedge hclk) contact <= w[29:24];
      wr(0, {15'h0, w[4], 3'h0, w[3], 3'h0, w[2], 3'h0, w[1], 3'h0, w[0]});
      wr(1, {31'h0, w[5]});
      `WT(act === (w[29:24] ^ w[5:0]))
      `CHK(act, w[29:24] ^ w[5:0])
    end
    // 2 ms filter rejects glitches
    wr(0, 0);
    wr(1, 0);
    wr(2, 2);
    @(posedge hclk) contact <= 6'h0;
    `WT(act === 6'h0)
    repeat (3) begin
      @(posedge hclk) contact <= 6'h08;
      repeat (8) @(posedge hclk);
      contact <= 6'h0;
      repeat (8) @(posedge hclk);
    end
    `CHK(act[3], 1'b0)
    @(posedge hclk) contact <= 6'h08;
    repeat (8) @(posedge hclk);
    `CHK(act[3], 1'b0)
    `WT(act[3] === 1'b1)
    // 200 ms delays on terminal 1
    wr(3, 2);
    wr(6, 2);
    @(posedge hclk) contact <= 6'h01;
    repeat (600) @(posedge hclk);
    `CHK(act[0], 1'b0)
    `WT(act[0] === 1'b1)
    @(posedge hclk) contact <= 6'h0;
    repeat (600) @(posedge hclk);
    `CHK(act[0], 1'b1)
    `WT(act[0] === 1'b0)
    wr(3, 0);
    wr(6, 0);
    wr(2, 0);
    // Curves 1 and 3 alike; input 2 in current mode
    for (i = 12; i < 26; i += 10) begin
      wr(6'(i), 200);
      wr(6'(i + 1), 32'hfe0c);
      wr(6'(i + 2), 800);
      wr(6'(i + 3), 700);
    end
    wr(16, 0);
    wr(21, 0);
    wr(10, 32'h31);
    wr(32, 32'h202);
    for (k = 0; k < 8; k++) begin
      v1 = $urandom_range(1400, 0) - 300;
      v2 = 2 * $urandom_range(600, 0);
      if (k == 0) begin v1 = 1200; v2 = 0; end
      w = $urandom;
      wr(11, {27'h0, w[1], 3'h0, w[0]});
      e1 = crv(v1, w[0]);
      e2 = crv(v2 / 2, w[1]);
      @(posedge hclk) a1 <= 16'(v1);
      a2 <= 16'(v2);
      `WT(s1 === 16'(e1) && s2 === 16'(e2))
      `CHK(s1, 16'(e1))
      `CHK(s2, 16'(e2))
    end
    // Curve 2 on input 1, curve 4 on input 2
    wr(10, 32'h42);
    @(posedge hclk) a1 <= 16'd500;
    `WT(s1 === 16'd500 && s2 === 16'h0)
    `CHK(s1, 16'd500)
    `CHK(s2, 16'h0)
    // Pulse rate from the pulse pin only
    wr(30, 0);
    wr(28, 1000);
    for (k = 0; k < 3; k++) begin
      e1 = k == 0 ? 100 : (k == 1 ? 250 : 0);
      @(posedge hclk) half <= k == 0 ? 8'd5 : 8'd2;
      on_di5 <= k == 2;
      `WT(sp === 16'(e1))
      repeat (150) @(posedge hclk);
      `CHK(sp, 16'(e1))
    end
    @(posedge hclk) half <= 8'h0;
    on_di5 <= 1'b0;
    // Random ramp rate, both scales
    rate = $urandom_range(65535, 1);
    wr(9, rate);
    for (k = 0; k < 4; k++) begin
      if (k == 1) wr(32, 32'h1);
      w[1:0] = k < 2 ? 2'b01 : (k == 2 ? 2'b10 : 2'b11);
      @(posedge hclk) contact <= {1'b0, w[1:0], 3'h0};
      `WT(act[4:3] === w[1:0])
      repeat (5) @(negedge hclk);
      meas;
      `CHK(a, 40'((k == 3 ? 0 : (k == 2 ? -50 : (k == 1 ? 50 : 5))) * rate))
      repeat (100) @(negedge hclk);
    end
    // Travel lock in shuttle mode only
    @(posedge hclk) contact <= 6'h0;
    wr(31, 2);
    wr(32, 32'h52);
    `WT(act === 6'h0)
    @(posedge hclk) contact <= 6'h01;
    `WT(lock === 1'b1)
    repeat (50) @(posedge hclk);
    `CHK(lock, 1'b1)
    `WT(lock === 1'b0)
    wr(32, 32'h2);
    @(posedge hclk) contact <= 6'h03;
    repeat (200) @(posedge hclk);
    `CHK(lock, 1'b0)
    end_of_test;
  end
endmodule // test_itc_top
bind itc_top itc_top_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .input_active_q(input_active_q), .ai1_setting_q(ai1_setting_q),
  .ai2_setting_q(ai2_setting_q), .pulse_setting_q(pulse_setting_q),
  .updown_freq_q(updown_freq_q), .travel_lock_q(travel_lock_q));
